/* File: rtl/ebws_top.sv */
// Write strobe generator for the shared port five bit two pin of the external bus.
`timescale 1ns/1ps
`default_nettype none
`include "ebws_map.svh"

module ebws_top (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          bus_write_phase,
    input  wire logic                          bus_read_phase,
    input  wire logic                          bus_word_width,
    input  wire logic                          bus_addr_lsb,
    input  wire logic                          port_five_function_select,
    input  wire logic [`EBWS_CFG_WIDTH-1:0]    chip_config_zero,
    input  wire logic                          port_data_out,
    input  wire logic                          port_data_oe,
    input  wire logic                          port_five_bit_two_in,
    output var  logic                          port_five_bit_two_out,
    output var  logic                          port_five_bit_two_oe,
    output var  logic                          read_strobe_n,
    output var  logic                          port_pin_level,
    output var  ebws_pkg::ebws_state_t         bus_state
);
    import ebws_pkg::*;

    // Next value of the cycle tracker.
    ebws_state_t next_state;
    // Strobe kind decoded from the configuration byte.
    ebws_kind_t  kind;
    // Two-stage synchroniser for the pin input; stage one feeds stage two only.
    // The pin comes from the board, so its first sample may be metastable.
    logic        pin_meta;
    // Next pin drive in either mode.
    wire         next_pin_out;
    wire         next_pin_oe;
    // Carrier between this module and the strobe decoder.
    ebws_strobe_if sif ();

    // A write phase takes priority when the bus unit raises both together.
    assign next_state = bus_write_phase ? EBWS_WRITE
                      : bus_read_phase  ? EBWS_READ
                      : EBWS_IDLE;

    // Configuration bit two set picks the plain strobe, clear picks the low-byte one.
    assign kind = chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT] ? EBWS_KIND_PLAIN
                                                           : EBWS_KIND_LOW_BYTE;

    // Only external cycles reach the tracker, so internal accesses leave the strobes high.
    assign sif.wr_active  = (next_state == EBWS_WRITE);
    assign sif.rd_active  = (next_state == EBWS_READ);
    assign sif.word_width = bus_word_width;
    assign sif.addr_lsb   = bus_addr_lsb;
    assign sif.kind       = kind;

    // The decoder works out both strobe levels for the coming cycle.
    ebws_strobe_dec u_dec (
        .sif (sif)
    );

    // In special-function mode the pin always drives the strobe; otherwise the port owns it.
    assign next_pin_out = port_five_function_select ? sif.next_wr_n : port_data_out;
    assign next_pin_oe  = port_five_function_select ? 1'b1 : port_data_oe;

    // Cycle tracker register.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_state <= EBWS_IDLE;
        end else begin
            bus_state <= next_state;
        end
    end

    // Pin drive registers; reset releases the pin to the idle port state.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_five_bit_two_out <= `EBWS_PORT_RESET_DATA;
            port_five_bit_two_oe  <= `EBWS_PORT_RESET_OE;
        end else begin
            port_five_bit_two_out <= next_pin_out;
            port_five_bit_two_oe  <= next_pin_oe;
        end
    end

    // Read strobe register; it idles high through reset.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            read_strobe_n <= `EBWS_STROBE_IDLE;
        end else begin
            read_strobe_n <= sif.next_rd_n;
        end
    end

    // Pin input synchroniser, read back as the port bit level.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_meta       <= 1'b0;
            port_pin_level <= 1'b0;
        end else begin
            pin_meta       <= port_five_bit_two_in;
            port_pin_level <= pin_meta;
        end
    end

    // Checks below all sample on the block clock and are held off during reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // A write cycle in special-function mode with the plain strobe selected.
    sequence s_plain_write;
        port_five_function_select && chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && bus_write_phase;
    endsequence

    // The same mode with no external write under way.
    sequence s_plain_quiet;
        port_five_function_select && chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && !bus_write_phase;
    endsequence

    // Low-byte strobe mode on a 16-bit bus writing the high byte alone.
    sequence s_high_byte_write;
        port_five_function_select && !chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && bus_write_phase && bus_word_width && bus_addr_lsb;
    endsequence

    // Two cycles in a row of an external read with no write beside it.
    sequence s_read_two;
        bus_read_phase && !bus_write_phase
            ##1 bus_read_phase && !bus_write_phase;
    endsequence

    // Plain strobe falls one cycle after an external write begins and is driven.
    chk_plain_write_low: assert property (
        s_plain_write |=> !port_five_bit_two_out && port_five_bit_two_oe)
        else $error("Plain write strobe not low during external write.");

    // Plain strobe stays high outside writes, including reads.
    chk_plain_idle_high: assert property (
        s_plain_quiet |=> port_five_bit_two_out)
        else $error("Plain write strobe low outside an external write.");

    // A lone high-byte write on a 16-bit bus leaves the low-byte strobe high.
    chk_high_byte_skip: assert property (
        s_high_byte_write |=> port_five_bit_two_out)
        else $error("Low-byte strobe asserted for a high-byte-only write.");

    // An even-address write on a 16-bit bus asserts the low-byte strobe.
    chk_low_word_write: assert property (
        port_five_function_select && !chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && bus_write_phase && bus_word_width && !bus_addr_lsb
        |=> !port_five_bit_two_out)
        else $error("Low-byte strobe missing on a low-byte or word write.");

    // On an 8-bit bus every write asserts the low-byte strobe at either address.
    chk_byte_bus_write: assert property (
        port_five_function_select && !chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && bus_write_phase && !bus_word_width
        |=> !port_five_bit_two_out)
        else $error("Low-byte strobe missing on an 8-bit bus write.");

    // The pin follows the chosen strobe: plain and low-byte differ only on high-byte writes.
    chk_kind_select: assert property (
        port_five_function_select && bus_write_phase && bus_word_width && bus_addr_lsb
        |=> port_five_bit_two_out == !$past(chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]))
        else $error("Strobe kind does not follow configuration bit two.");

    // A read phase with no write beside it pulls the read strobe low for as long as it lasts.
    chk_read_strobe: assert property (
        s_read_two
        |=> !read_strobe_n && $past(!read_strobe_n))
        else $error("Read strobe not low through an external read.");

    // In port mode the pin mirrors the port data and enable one cycle later.
    chk_port_mode: assert property (
        !port_five_function_select
        |=> port_five_bit_two_out == $past(port_data_out)
            && port_five_bit_two_oe == $past(port_data_oe))
        else $error("Pin not released to the port in port mode.");

    // The pin level read back is the pin input two cycles earlier.
    chk_sync_delay: assert property (
        $past(nrst) ##1 nrst |-> port_pin_level == $past(port_five_bit_two_in, 2))
        else $error("Pin synchroniser delay is not two cycles.");

    // In special-function mode the pin is always driven, idling high between strobes.
    chk_strobe_drive: assert property (
        port_five_function_select |=> port_five_bit_two_oe)
        else $error("Pin not driven in special-function mode.");

    // The low-byte strobe stays high whenever no external write is under way.
    chk_low_idle_high: assert property (
        port_five_function_select && !chip_config_zero[`EBWS_CFG_PLAIN_SEL_BIT]
            && !bus_write_phase
        |=> port_five_bit_two_out)
        else $error("Low-byte strobe low outside an external write.");

    // The read strobe stays high through writes and idle cycles.
    chk_read_idle_high: assert property (
        !bus_read_phase || bus_write_phase |=> read_strobe_n)
        else $error("Read strobe low outside an external read.");

    // The tracker marks a write one edge after the write phase rises; write beats read.
    chk_state_write: assert property (
        bus_write_phase |=> bus_state == EBWS_WRITE)
        else $error("Tracker not in the write state during an external write.");

    // The tracker marks a read only when no write is under way.
    chk_state_read: assert property (
        bus_read_phase && !bus_write_phase |=> bus_state == EBWS_READ)
        else $error("Tracker not in the read state during an external read.");

    // Without either phase the tracker rests idle, so internal accesses raise no strobe.
    chk_state_idle: assert property (
        !bus_read_phase && !bus_write_phase |=> bus_state == EBWS_IDLE)
        else $error("Tracker not idle between external cycles.");

endmodule : ebws_top

`default_nettype wire

/* File: rtl/ebws_map.svh */
// Constants for the external bus write strobe block: bit positions, idle levels, sync depth.
`ifndef EBWS_MAP_SVH
`define EBWS_MAP_SVH

// Bit of the chip configuration byte that picks the plain write strobe when set.
`define EBWS_CFG_PLAIN_SEL_BIT 2
// Width of the chip configuration byte.
`define EBWS_CFG_WIDTH 8
// Level of every active-low strobe while it is not asserted.
`define EBWS_STROBE_IDLE 1'b1
// Level of an active-low strobe while it is asserted.
`define EBWS_STROBE_ON 1'b0
// Reset level of the port bit data and enable seen on the pin.
`define EBWS_PORT_RESET_DATA 1'b1
`define EBWS_PORT_RESET_OE 1'b0
// Number of flip-flops that the pin input passes before logic reads it.
`define EBWS_SYNC_STAGES 2

`endif

/* File: rtl/ebws_pkg.sv */
// Types shared by the external bus write strobe block.
`default_nettype none

package ebws_pkg;

    // Bus cycle tracker states, one-hot.
    typedef enum logic [2:0] {
        EBWS_IDLE  = 3'b001,
        EBWS_WRITE = 3'b010,
        EBWS_READ  = 3'b100
    } ebws_state_t;

    // Which write strobe the shared pin carries in special-function mode.
    typedef enum logic {
        EBWS_KIND_LOW_BYTE = 1'b0,
        EBWS_KIND_PLAIN    = 1'b1
    } ebws_kind_t;

endpackage : ebws_pkg

`default_nettype wire

/* File: rtl/ebws_strobe_if.sv */
// Interface carrying cycle facts into the strobe decoder and next strobe levels back out.
`timescale 1ns/1ps
`default_nettype none

interface ebws_strobe_if;
    import ebws_pkg::*;
    logic       wr_active;   // An external write cycle is in progress next cycle.
    logic       rd_active;   // An external read cycle is in progress next cycle.
    logic       word_width;  // High for 16-bit bus cycles, low for 8-bit ones.
    logic       addr_lsb;    // Byte address bit 0 of the current cycle.
    ebws_kind_t kind;        // Strobe kind picked by configuration.
    logic       next_wr_n;   // Next level of the selected write strobe.
    logic       next_rd_n;   // Next level of the read strobe.

    // The decoder reads the cycle facts and drives the next strobe levels.
    modport dec (
        input  wr_active, rd_active, word_width, addr_lsb, kind,
        output next_wr_n, next_rd_n
    );

    // The top drives the cycle facts and registers the next strobe levels.
    modport top (
        output wr_active, rd_active, word_width, addr_lsb, kind,
        input  next_wr_n, next_rd_n
    );
endinterface : ebws_strobe_if

`default_nettype wire

/* File: rtl/ebws_strobe_dec.sv */
// Combinational decoder that turns bus cycle facts into write and read strobe levels.
`timescale 1ns/1ps
`default_nettype none
`include "ebws_map.svh"

module ebws_strobe_dec (
    ebws_strobe_if.dec sif
);
    import ebws_pkg::*;

    // The low byte is written by a low-byte write or a word write, both at an even address.
    wire low_byte_hit;
    // Plain strobe level: low through every external write.
    wire plain_n;
    // Low-byte strobe level, depending on bus width.
    wire low_n;

    assign low_byte_hit = ~sif.addr_lsb;
    assign plain_n = sif.wr_active ? `EBWS_STROBE_ON : `EBWS_STROBE_IDLE;
    // An 8-bit cycle strobes every write; a 16-bit cycle skips a lone high-byte write.
    assign low_n = (sif.wr_active && (!sif.word_width || low_byte_hit))
                 ? `EBWS_STROBE_ON : `EBWS_STROBE_IDLE;
    assign sif.next_wr_n = (sif.kind == EBWS_KIND_PLAIN) ? plain_n : low_n;
    assign sif.next_rd_n = sif.rd_active ? `EBWS_STROBE_ON : `EBWS_STROBE_IDLE;

endmodule : ebws_strobe_dec

`default_nettype wire

/* File: verification/ebws_ext_mem_model.sv */
// Behavioural external memory that counts the strobes it sees on the bus.
`timescale 1ns/1ps
`default_nettype none

module ebws_ext_mem_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    output var  logic [7:0] wr_count,
    output var  logic [7:0] rd_count
);
    logic wr_n_q; // Write pin level one cycle ago.
    logic rd_n_q; // Read strobe level one cycle ago.

    // Each falling strobe starts one transfer, so back-to-back cycles with no high gap count as one.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_n_q   <= 1'b1;
            rd_n_q   <= 1'b1;
            wr_count <= 8'h00;
            rd_count <= 8'h00;
        end else begin
            wr_n_q <= wr_n;
            rd_n_q <= rd_n;
            if (wr_n_q && !wr_n) wr_count <= wr_count + 8'h01;
            if (rd_n_q && !rd_n) rd_count <= rd_count + 8'h01;
        end
    end
endmodule : ebws_ext_mem_model

`default_nettype wire

/* File: verification/ebws_top_tb_top.sv */
// Self-checking bench for the external bus write strobe block.
`timescale 1ns/1ps
`default_nettype none

module ebws_top_tb_top;
    import ebws_pkg::*;
    logic        clk = 1'b0;   // Bench clock, 8 ns period.
    logic        nrst = 1'b0;  // Synchronous active-low reset.
    logic        wr_ph = 1'b0; // Write phase from the bus unit.
    logic        rd_ph = 1'b0; // Read phase from the bus unit.
    logic        ww = 1'b0;    // Word width select.
    logic        lsb = 1'b0;   // Byte address bit 0.
    logic        sel = 1'b0;   // Pin function select.
    logic [7:0]  cfg = 8'h00;  // Configuration byte.
    logic        pdo = 1'b0;   // Port data in port mode.
    logic        poe = 1'b0;   // Port drive enable in port mode.
    logic        p_out;        // Pin output value.
    logic        p_oe;         // Pin output enable.
    logic        rd_n;         // Read strobe.
    logic        p_lvl;        // Synchronised pin level.
    ebws_state_t st;           // Bus tracker state.
    logic        pin;          // Pin wire with its pull-up.
    logic [7:0]  wr_cnt;       // Write strobes seen by the memory.
    logic [7:0]  rd_cnt;       // Read strobes seen by the memory.
    int          bad_count = 0;
    int          n_compared = 0;
    int          cycles = 0;   // Cycles run, for the hang limit.

    // The pin floats to its pull-up whenever nobody drives it.
    assign pin = p_oe ? p_out : 1'b1;

    always #4 clk = ~clk;

    ebws_top dut_u (.clk(clk), .nrst(nrst), .bus_write_phase(wr_ph), .bus_read_phase(rd_ph),
        .bus_word_width(ww), .bus_addr_lsb(lsb), .port_five_function_select(sel),
        .chip_config_zero(cfg), .port_data_out(pdo), .port_data_oe(poe),
        .port_five_bit_two_in(pin), .port_five_bit_two_out(p_out),
        .port_five_bit_two_oe(p_oe), .read_strobe_n(rd_n), .port_pin_level(p_lvl),
        .bus_state(st));

    ebws_ext_mem_model mem_u (.clk(clk), .nrst(nrst), .wr_n(pin), .rd_n(rd_n),
        .wr_count(wr_cnt), .rd_count(rd_cnt));

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Counts one comparison and reports it when it differs.
    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Applies one cycle of bus facts at a falling edge and waits for the result.
    task automatic step(input logic w, input logic r, input logic wd, input logic a);
        wr_ph = w;
        rd_ph = r;
        ww = wd;
        lsb = a;
        @(negedge clk);
    endtask : step

    // Compares the pin, its enable, the read strobe and the tracker at once.
    task automatic expect_out(input logic o, input logic e, input logic r, input logic [2:0] s);
        check("pin_out", {2'b00, p_out}, {2'b00, o});
        check("pin_oe", {2'b00, p_oe}, {2'b00, e});
        check("read_strobe_n", {2'b00, rd_n}, {2'b00, r});
        check("bus_state", st, s);
    endtask : expect_out

    // Holds reset for three cycles, checks the idle levels, then releases.
    task automatic do_reset;
        nrst = 1'b0;
        step(1'b1, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 1'b1, 1'b0);
        expect_out(1'b1, 1'b0, 1'b1, 3'b001);
        check("pin_level", {2'b00, p_lvl}, 3'b000);
        nrst = 1'b1;
        step(1'b0, 1'b0, 1'b0, 1'b0);
        step(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test reset done");
    endtask : do_reset

    // Plain strobe with reads, two writes split by a read and write-over-read priority.
    task automatic test_plain;
        logic [7:0] w0;
        logic [7:0] r0;
        sel = 1'b1;
        cfg = 8'h04;
        w0 = wr_cnt;
        r0 = rd_cnt;
        step(1'b1, 1'b0, 1'b1, 1'b1);
        expect_out(1'b0, 1'b1, 1'b1, 3'b010);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        expect_out(1'b1, 1'b1, 1'b0, 3'b100);
        step(1'b1, 1'b1, 1'b0, 1'b0);
        expect_out(1'b0, 1'b1, 1'b1, 3'b010);
        step(1'b0, 1'b0, 1'b1, 1'b0);
        expect_out(1'b1, 1'b1, 1'b1, 3'b001);
        step(1'b0, 1'b0, 1'b1, 1'b0);
        check("write_count", 3'(wr_cnt - w0), 3'h2);
        check("read_count", 3'(rd_cnt - r0), 3'h1);
        $display("test plain done");
    endtask : test_plain

    // Low-byte strobe on a 16-bit bus: low or word writes only; other config bits set.
    task automatic test_low16;
        cfg = 8'hfb;
        step(1'b1, 1'b0, 1'b1, 1'b0);
        expect_out(1'b0, 1'b1, 1'b1, 3'b010);
        step(1'b1, 1'b0, 1'b1, 1'b1);
        expect_out(1'b1, 1'b1, 1'b1, 3'b010);
        step(1'b0, 1'b0, 1'b1, 1'b0);
        expect_out(1'b1, 1'b1, 1'b1, 3'b001);
        $display("test low16 done");
    endtask : test_low16

    // Low-byte strobe on an 8-bit bus: every write, neither byte address excluded.
    task automatic test_low8;
        cfg = 8'h00;
        step(1'b1, 1'b0, 1'b0, 1'b1);
        expect_out(1'b0, 1'b1, 1'b1, 3'b010);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        expect_out(1'b0, 1'b1, 1'b1, 3'b010);
        step(1'b0, 1'b1, 1'b0, 1'b1);
        expect_out(1'b1, 1'b1, 1'b0, 3'b100);
        $display("test low8 done");
    endtask : test_low8

    // Port mode ignores a running write; the pin follows the port bit and reads back.
    task automatic test_port;
        sel = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pdo = i[0];
            poe = i[1];
            step(1'b1, 1'b0, 1'b0, 1'b0);
            expect_out(i[0], i[1], 1'b1, 3'b010);
            step(1'b1, 1'b0, 1'b0, 1'b0);
            step(1'b1, 1'b0, 1'b0, 1'b0);
            check("pin_level", {2'b00, p_lvl}, {2'b00, i[1] ? i[0] : 1'b1});
        end
        $display("test port done");
    endtask : test_port

    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end

    // Main sequence, with a second reset in mid-run.
    initial begin
        @(negedge clk);
        do_reset();
        test_plain();
        test_low16();
        test_low8();
        test_port();
        sel = 1'b1;
        do_reset();
        test_plain();
        complete_run();
    end
endmodule : ebws_top_tb_top

`default_nettype wire
